/* rtl/homing_pkg.sv */
package homing_pkg;

    // Control word values that frame a homing trigger
    localparam logic [15:0] CW_ENABLED       = 16'h000f;
    localparam logic [15:0] CW_HOMING_START  = 16'h001f;

    // Supported method window
    localparam logic [7:0]  METHOD_FIRST     = 8'h15;
    localparam logic [7:0]  METHOD_LAST      = 8'h1a;
    // Offset (from the first method) of the first method that watches the positive limit
    localparam logic [2:0]  LIMIT_METHOD_OFS = 3'h2;

    // Which sequence is being followed
    localparam logic [1:0]  PATH_CLEAR       = 2'h0;
    localparam logic [1:0]  PATH_LIMIT       = 2'h1;
    localparam logic [1:0]  PATH_ACTIVE      = 2'h2;

    // Step word fields
    localparam int          STEP_VALID       = 3;
    localparam int          STEP_FWD         = 2;
    localparam int          STEP_HIGH        = 1;
    localparam int          STEP_RISE        = 0;
    localparam int          STEP_IDX_W       = 3;

    // Reversal dwell
    localparam int unsigned CLK_PERIOD_NS    = 50;
    localparam int unsigned DECEL_TIME_NS    = 100000;
    localparam int unsigned DECEL_CYCLES     = (DECEL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DECEL_CNT_W      = 12;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_DECEL,
        ST_STOP,
        ST_DONE
    } state_t;

endpackage

/* rtl/home_switch_edge.sv */
`timescale 1ns/10ps

module home_switch_edge (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_switch,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);

    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;
    logic prev_r;
    logic prev_nxt;

    // Two-stage synchroniser, then one more stage for the edge compare
    always_comb begin
        meta_nxt = i_switch;
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Rise is inactive to active, fall the opposite; meta_r feeds nothing else
    assign o_level = sync_r;
    assign o_rise  = sync_r & ~prev_r;
    assign o_fall  = ~sync_r & prev_r;

    // A rise must match the pin two and three clocks back, so the chain length is checked too
    property p_edge_meaning;
        @(posedge i_clk) disable iff (i_reset) o_rise |-> $past(i_switch, 2) && !$past(i_switch, 3);
    endproperty
    a_edge_meaning: assert property (p_edge_meaning) else $error("rising edge misreported");

endmodule

/* rtl/home_switch_homing_sequencer.sv */
// Summary of operation
// - 21 inactive: reverse fast, forward slow, stop fall
// - 21/26 active: forward slow, stop at fall
// - 22 inactive: reverse fast, forward, reverse, stop rise
// - 22/25 active: forward slow, reverse slow, stop rise
// - 23-26 inactive: forward fast, limit turns reverse
// - 23 clear: reverse slow at rise, stop fall
// - 23 limit: reverse, forward, reverse, stop fall
// - 23 active: reverse slow, stop at fall
// - 24 clear: reverse slow, forward slow, stop rise
// - 24 limit: reverse slow, forward slow, stop rise
// - 24 active: reverse slow, forward slow, stop rise
// - 25 clear: forward slow, reverse slow, stop rise
// - 25 limit: forward slow, reverse slow, stop rise
// - 26 clear: forward, reverse, forward slow, stop fall
// - 26 limit: forward slow at rise, stop fall
// - Home switch only decides stops, no index
`timescale 1ns/10ps

module home_switch_homing_sequencer (
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic [15:0] I_CONTROL_WORD,
    input  wire logic [7:0]  I_HOMING_METHOD_SELECT,
    input  wire logic        I_HOME_SWITCH_INPUT,
    input  wire logic        I_POS_LIMIT,
    input  wire logic        I_AXIS_STILL,
    output logic             O_MOVE,
    output logic             O_DIR_FWD,
    output logic             O_SPEED_HIGH,
    output logic             O_DECEL,
    output logic             O_BUSY,
    output logic             O_DONE,
    output logic             O_ERROR
);

    homing_pkg::state_t state_r;
    homing_pkg::state_t state_nxt;
    logic [2:0]                          method_r;
    logic [2:0]                          method_nxt;
    logic [1:0]                          path_r;
    logic [1:0]                          path_nxt;
    logic [homing_pkg::STEP_IDX_W-1:0]   idx_r;
    logic [homing_pkg::STEP_IDX_W-1:0]   idx_nxt;
    logic                                move_r;
    logic                                move_nxt;
    logic                                fwd_r;
    logic                                fwd_nxt;
    logic                                high_r;
    logic                                high_nxt;
    logic                                done_r;
    logic                                done_nxt;
    logic                                err_r;
    logic                                err_nxt;
    logic [homing_pkg::DECEL_CNT_W-1:0]  cnt_r;
    logic [homing_pkg::DECEL_CNT_W-1:0]  cnt_nxt;
    logic [15:0]                         cw_prev_r;
    logic [15:0]                         cw_prev_nxt;
    logic                                sw_level;
    logic                                sw_rise;
    logic                                sw_fall;
    logic                                start_evt;
    logic                                method_ok;
    logic [2:0]                          sel_ofs;
    logic [3:0]                          cur_step;
    logic [3:0]                          nxt_step;
    logic                                edge_hit;
    logic                                limit_turn;

    localparam logic [homing_pkg::DECEL_CNT_W-1:0] DECEL_LOAD =
        homing_pkg::DECEL_CNT_W'(homing_pkg::DECEL_CYCLES - 1);

    // Step table: {valid, forward, high speed, wait for rise (else fall)}
    function automatic logic [3:0] step_info(input logic [2:0] m, input logic [1:0] p,
                                              input logic [homing_pkg::STEP_IDX_W-1:0] i);
        logic [3:0] key;
        key = {p, i[1:0]};
        step_info = 4'h0;
        if (!i[2]) begin
            // One hex digit of method offset, one of {path, step}; unlisted steps end the run
            case ({m, key})
                7'h00: step_info = 4'hb;
                7'h01: step_info = 4'hc;
                7'h08: step_info = 4'hc;
                7'h10: step_info = 4'hb;
                7'h11: step_info = 4'hc;
                7'h12: step_info = 4'h9;
                7'h18: step_info = 4'hc;
                7'h19: step_info = 4'h9;
                7'h20: step_info = 4'hf;
                7'h21: step_info = 4'h8;
                7'h24: step_info = 4'hb;
                7'h25: step_info = 4'h8;
                7'h26: step_info = 4'hd;
                7'h27: step_info = 4'h8;
                7'h28: step_info = 4'h8;
                7'h30: step_info = 4'hf;
                7'h31: step_info = 4'h8;
                7'h32: step_info = 4'hd;
                7'h34: step_info = 4'hb;
                7'h35: step_info = 4'h8;
                7'h36: step_info = 4'hd;
                7'h38: step_info = 4'h8;
                7'h39: step_info = 4'hd;
                7'h40: step_info = 4'hf;
                7'h41: step_info = 4'hc;
                7'h42: step_info = 4'h9;
                7'h44: step_info = 4'hb;
                7'h45: step_info = 4'hc;
                7'h46: step_info = 4'h9;
                7'h48: step_info = 4'hc;
                7'h49: step_info = 4'h9;
                7'h50: step_info = 4'hf;
                7'h51: step_info = 4'hc;
                7'h52: step_info = 4'h9;
                7'h53: step_info = 4'hc;
                7'h54: step_info = 4'hb;
                7'h55: step_info = 4'hc;
                7'h58: step_info = 4'hc;
                default: step_info = 4'h0;
            endcase
        end
    endfunction

    home_switch_edge u_home_edge (
        .i_clk    (I_CLK),
        .i_reset  (I_RESET),
        .i_switch (I_HOME_SWITCH_INPUT),
        .o_level  (sw_level),
        .o_rise   (sw_rise),
        .o_fall   (sw_fall)
    );

    // Trigger decode and table lookups
    always_comb begin
        start_evt  = (cw_prev_r == homing_pkg::CW_ENABLED) &&
                     (I_CONTROL_WORD == homing_pkg::CW_HOMING_START);
        method_ok  = (I_HOMING_METHOD_SELECT >= homing_pkg::METHOD_FIRST) &&
                     (I_HOMING_METHOD_SELECT <= homing_pkg::METHOD_LAST);
        sel_ofs    = 3'(I_HOMING_METHOD_SELECT - homing_pkg::METHOD_FIRST);
        cur_step   = step_info(method_r, path_r, idx_r);
        nxt_step   = step_info(method_r, path_r, idx_r + 3'h1);
        // Home switch edges end a step, the limit only the first fast forward one; no index pulse is looked at
        edge_hit   = cur_step[homing_pkg::STEP_RISE] ? sw_rise : sw_fall;
        // Limit only matters on the first fast forward leg
        limit_turn = I_POS_LIMIT && (path_r == homing_pkg::PATH_CLEAR) && (idx_r == 3'h0) &&
                     (method_r >= homing_pkg::LIMIT_METHOD_OFS);
    end

    // Sequencer next state
    always_comb begin
        logic [3:0] first;
        first       = step_info(sel_ofs, sw_level ? homing_pkg::PATH_ACTIVE : homing_pkg::PATH_CLEAR, 3'h0);
        state_nxt   = state_r;
        method_nxt  = method_r;
        path_nxt    = path_r;
        idx_nxt     = idx_r;
        move_nxt    = move_r;
        fwd_nxt     = fwd_r;
        high_nxt    = high_r;
        done_nxt    = done_r;
        err_nxt     = err_r;
        cnt_nxt     = cnt_r;
        cw_prev_nxt = I_CONTROL_WORD;
        if (start_evt) begin
            // A new trigger restarts from scratch, whatever was running
            done_nxt   = 1'b0;
            idx_nxt    = 3'h0;
            method_nxt = sel_ofs;
            path_nxt   = sw_level ? homing_pkg::PATH_ACTIVE : homing_pkg::PATH_CLEAR;
            if (method_ok) begin
                err_nxt   = 1'b0;
                state_nxt = homing_pkg::ST_RUN;
                move_nxt  = 1'b1;
                fwd_nxt   = first[homing_pkg::STEP_FWD];
                high_nxt  = first[homing_pkg::STEP_HIGH];
            end else begin
                err_nxt   = 1'b1;
                state_nxt = homing_pkg::ST_IDLE;
                move_nxt  = 1'b0;
            end
        end else begin
            case (state_r)
                homing_pkg::ST_RUN: begin
                    if (limit_turn) begin
                        // Fast forward to fast reverse always reverses, so dwell first
                        path_nxt  = homing_pkg::PATH_LIMIT;
                        idx_nxt   = 3'h0;
                        cnt_nxt   = DECEL_LOAD;
                        state_nxt = homing_pkg::ST_DECEL;
                    end else if (edge_hit) begin
                        idx_nxt = idx_r + 3'h1;
                        if (!nxt_step[homing_pkg::STEP_VALID]) begin
                            move_nxt  = 1'b0;
                            state_nxt = homing_pkg::ST_STOP;
                        end else if (nxt_step[homing_pkg::STEP_FWD] != fwd_r) begin
                            cnt_nxt   = DECEL_LOAD;
                            state_nxt = homing_pkg::ST_DECEL;
                        end else begin
                            // Same direction: speed drop needs no dwell, ramp is the drive's
                            high_nxt = nxt_step[homing_pkg::STEP_HIGH];
                        end
                    end
                end
                homing_pkg::ST_DECEL: begin
                    // Old command holds; edges are ignored while the axis stops
                    if (cnt_r == '0) begin
                        fwd_nxt   = cur_step[homing_pkg::STEP_FWD];
                        high_nxt  = cur_step[homing_pkg::STEP_HIGH];
                        state_nxt = homing_pkg::ST_RUN;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                homing_pkg::ST_STOP: begin
                    if (I_AXIS_STILL) begin
                        done_nxt  = 1'b1;
                        state_nxt = homing_pkg::ST_DONE;
                    end
                end
                homing_pkg::ST_DONE: state_nxt = homing_pkg::ST_DONE;
                homing_pkg::ST_IDLE: state_nxt = homing_pkg::ST_IDLE;
                default: state_nxt = homing_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_r   <= homing_pkg::ST_IDLE;
            method_r  <= 3'h0;
            path_r    <= 2'h0;
            idx_r     <= 3'h0;
            move_r    <= 1'b0;
            fwd_r     <= 1'b0;
            high_r    <= 1'b0;
            done_r    <= 1'b0;
            err_r     <= 1'b0;
            cnt_r     <= '0;
            cw_prev_r <= 16'h0000;
        end else begin
            state_r   <= state_nxt;
            method_r  <= method_nxt;
            path_r    <= path_nxt;
            idx_r     <= idx_nxt;
            move_r    <= move_nxt;
            fwd_r     <= fwd_nxt;
            high_r    <= high_nxt;
            done_r    <= done_nxt;
            err_r     <= err_nxt;
            cnt_r     <= cnt_nxt;
            cw_prev_r <= cw_prev_nxt;
        end
    end

    // Commands straight from flops
    assign O_MOVE       = move_r;
    assign O_DIR_FWD    = fwd_r;
    assign O_SPEED_HIGH = high_r;
    assign O_DECEL      = (state_r == homing_pkg::ST_DECEL);
    assign O_BUSY       = (state_r == homing_pkg::ST_RUN) || (state_r == homing_pkg::ST_DECEL) ||
                          (state_r == homing_pkg::ST_STOP);
    assign O_DONE       = done_r;
    assign O_ERROR      = err_r;

    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    property p_m21_clear_start;
        start_evt && method_ok && (sel_ofs == 3'h0) && !sw_level |=> O_MOVE && !O_DIR_FWD && O_SPEED_HIGH;
    endproperty
    a_m21_clear_start: assert property (p_m21_clear_start) else $error("method 21 clear start wrong");

    property p_active_fwd_start;
        start_evt && method_ok && ((sel_ofs == 3'h0) || (sel_ofs == 3'h5)) && sw_level
            |=> O_MOVE && O_DIR_FWD && !O_SPEED_HIGH;
    endproperty
    a_active_fwd_start: assert property (p_active_fwd_start) else $error("active start not slow forward");

    property p_limit_group_start;
        start_evt && method_ok && (sel_ofs >= 3'h2) && !sw_level |=> O_MOVE && O_DIR_FWD && O_SPEED_HIGH;
    endproperty
    a_limit_group_start: assert property (p_limit_group_start) else $error("limit group start not fast fwd");

    property p_m23_active_start;
        start_evt && method_ok && (sel_ofs == 3'h2) && sw_level |=> O_MOVE && !O_DIR_FWD && !O_SPEED_HIGH;
    endproperty
    a_m23_active_start: assert property (p_m23_active_start) else $error("method 23 active start wrong");

    property p_limit_turns;
        (state_r == homing_pkg::ST_RUN) && limit_turn && !start_evt
            |=> O_DECEL && (path_r == homing_pkg::PATH_LIMIT);
    endproperty
    a_limit_turns: assert property (p_limit_turns) else $error("limit hit did not start a dwell");

    // Dwell end read off cnt_r; a delay range as long as the dwell would choke the tools
    property p_limit_leg;
        O_DECEL && (cnt_r == '0) && (path_r == homing_pkg::PATH_LIMIT) && (idx_r == 3'h0) && !start_evt
            |=> O_MOVE && !O_DECEL && !O_DIR_FWD && O_SPEED_HIGH;
    endproperty
    a_limit_leg: assert property (p_limit_leg) else $error("limit hit did not turn to fast reverse");

    property p_reverse_after_dwell;
        $changed(O_DIR_FWD) && !$past(start_evt) |-> $past(O_DECEL) && O_MOVE;
    endproperty
    a_reverse_after_dwell: assert property (p_reverse_after_dwell) else $error("reversal without dwell");

    property p_dwell_holds;
        O_DECEL && !start_evt && (cnt_r != '0) |=> $stable(O_DIR_FWD);
    endproperty
    a_dwell_holds: assert property (p_dwell_holds) else $error("direction changed during dwell");

    property p_stop_on_edge;
        $fell(O_MOVE) && !$past(start_evt) |-> $past(sw_rise || sw_fall);
    endproperty
    a_stop_on_edge: assert property (p_stop_on_edge) else $error("stop not caused by home switch edge");

    property p_done_when_still;
        $rose(O_DONE) |-> !O_MOVE && $past(I_AXIS_STILL) && ($past(state_r) == homing_pkg::ST_STOP);
    endproperty
    a_done_when_still: assert property (p_done_when_still) else $error("done without stop");

    property p_bad_method;
        start_evt && !method_ok |=> O_ERROR && !O_MOVE && !O_BUSY;
    endproperty
    a_bad_method: assert property (p_bad_method) else $error("unsupported method not refused");

endmodule

/* verif/axis_partner.sv */
`timescale 1ns/10ps

module axis_partner #(
    parameter int SW_LO = 1000,
    parameter int SW_HI = 1100,
    parameter int LIM   = 1400
) (
    input  wire logic               i_clk,
    input  wire logic               i_load,
    input  wire logic signed [15:0] i_load_pos,
    input  wire logic               i_move,
    input  wire logic               i_dir_fwd,
    input  wire logic               i_speed_high,
    input  wire logic               i_decel,
    output logic                    o_home_sw,
    output logic                    o_limit,
    output logic                    o_still,
    output logic signed [15:0]      o_pos
);
    int still_cnt = 0;

    // Axis travel; it stands during the dwell, so the dwell length adds no overshoot
    always @(posedge i_clk) begin
        if (i_load) begin
            o_pos <= i_load_pos;
        end else if (i_move && !i_decel) begin
            o_pos <= o_pos + (i_dir_fwd ? 16'sd1 : -16'sd1) * (i_speed_high ? 16'sd4 : 16'sd1);
        end
        still_cnt <= i_move ? 0 : (still_cnt < 4 ? still_cnt + 1 : 4);
    end

    // Switch levels follow position; still lags the stop, as a real axis does
    assign o_home_sw = (o_pos >= 16'(SW_LO)) && (o_pos <= 16'(SW_HI));
    assign o_limit   = (o_pos >= 16'(LIM));
    assign o_still   = (still_cnt == 4);
endmodule

/* verif/home_switch_homing_sequencer_tb.sv */
`timescale 1ns/10ps

module home_switch_homing_sequencer_tb;
    localparam logic [1:0] RL = 2'h0;
    localparam logic [1:0] RH = 2'h1;
    localparam logic [1:0] FL = 2'h2;
    localparam logic [1:0] FH = 2'h3;

    logic               clk = 1'b0;
    logic               reset;
    logic [15:0]        cw;
    logic [7:0]         method;
    logic               load;
    logic signed [15:0] load_pos;
    logic               home_sw;
    logic               limit;
    logic               still;
    logic               move;
    logic               dir_fwd;
    logic               speed_high;
    logic               decel;
    logic               busy;
    logic               done;
    logic               error;
    int                 miscompares = 0;
    int                 checks_done = 0;
    int                 cycles = 0;
    int                 dwell_len = 0;
    int                 last_dwell = 0;
    logic [1:0]         legs[$];

    home_switch_homing_sequencer DUT (
        .I_CLK                  (clk),
        .I_RESET                (reset),
        .I_CONTROL_WORD         (cw),
        .I_HOMING_METHOD_SELECT (method),
        .I_HOME_SWITCH_INPUT    (home_sw),
        .I_POS_LIMIT            (limit),
        .I_AXIS_STILL           (still),
        .O_MOVE                 (move),
        .O_DIR_FWD              (dir_fwd),
        .O_SPEED_HIGH           (speed_high),
        .O_DECEL                (decel),
        .O_BUSY                 (busy),
        .O_DONE                 (done),
        .O_ERROR                (error)
    );

    axis_partner axis (
        .i_clk        (clk),
        .i_load       (load),
        .i_load_pos   (load_pos),
        .i_move       (move),
        .i_dir_fwd    (dir_fwd),
        .i_speed_high (speed_high),
        .i_decel      (decel),
        .o_home_sw    (home_sw),
        .o_limit      (limit),
        .o_still      (still),
        .o_pos        ()
    );

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Record each new travel command; the dwell holds the old one, so it is not a leg
    always @(negedge clk) begin
        if (move === 1'b1 && decel === 1'b0 && (legs.size() == 0 || legs[$] !== {dir_fwd, speed_high}))
            legs.push_back({dir_fwd, speed_high});
    end

    // Length of the latest finished dwell, in clock cycles
    always @(negedge clk) begin
        if (decel === 1'b1) begin
            dwell_len <= dwell_len + 1;
        end else if (dwell_len != 0) begin
            last_dwell <= dwell_len;
            dwell_len  <= 0;
        end
    end

    // Hang guard, well above the sum of all dwells and travel
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Inputs change a fixed 2 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic kick(input logic [7:0] m);
        cw = 16'h000f;
        step(2);
        cw = 16'h001f;
        method = m;
        step(1);
    endtask

    // Place the axis, home it, then compare the legs and where it came to rest
    task automatic run_home(input logic [7:0] m, input logic signed [15:0] p, input int n,
                            input logic [11:0] e, input logic sw_end);
        int t;
        load = 1'b1;
        load_pos = p;
        step(1);
        load = 1'b0;
        step(6);
        legs.delete();
        kick(m);
        step(1);
        check("move after start", move, 8'h01);
        t = 0;
        while (done !== 1'b1 && t < 20000) begin
            step(1);
            t++;
        end
        check("done", done, 8'h01);
        check("busy", busy, 8'h00);
        check("move", move, 8'h00);
        check("error", error, 8'h00);
        check("leg count", 8'(legs.size()), 8'(n));
        for (int i = 0; i < n && i < legs.size(); i++)
            check("leg", legs[i], e[2*(n-1-i) +: 2]);
        // Every multi-leg run here reverses at least once, so a whole dwell must have passed
        if (n > 1)
            check("dwell cycles", 16'(last_dwell), 16'(homing_pkg::DECEL_CYCLES));
        check("switch level at rest", home_sw, sw_end);
    endtask

    task automatic t_trigger();
        cw = 16'h0000;
        step(2);
        cw = 16'h001f;
        method = 8'h15;
        step(3);
        check("start without enabled word", busy, 8'h00);
    endtask

    task automatic t_bad_method();
        kick(8'h14);
        step(1);
        check("error below range", error, 8'h01);
        check("no motion", move, 8'h00);
        kick(8'h1b);
        step(1);
        check("error above range", error, 8'h01);
        check("no motion", move, 8'h00);
    endtask

    task automatic t_m21();
        run_home(8'h15, 16'sd1250, 2, {RH, FL}, 1'b0);
        run_home(8'h15, 16'sd1050, 1, {FL}, 1'b0);
    endtask

    task automatic t_m22();
        run_home(8'h16, 16'sd1250, 3, {RH, FL, RL}, 1'b1);
        run_home(8'h16, 16'sd1050, 2, {FL, RL}, 1'b1);
    endtask

    task automatic t_m23();
        run_home(8'h17, 16'sd900, 2, {FH, RL}, 1'b0);
        run_home(8'h17, 16'sd1250, 5, {FH, RH, RL, FL, RL}, 1'b0);
        run_home(8'h17, 16'sd1050, 1, {RL}, 1'b0);
    endtask

    task automatic t_m24();
        run_home(8'h18, 16'sd900, 3, {FH, RL, FL}, 1'b1);
        run_home(8'h18, 16'sd1250, 4, {FH, RH, RL, FL}, 1'b1);
        run_home(8'h18, 16'sd1050, 2, {RL, FL}, 1'b1);
    endtask

    task automatic t_m25();
        run_home(8'h19, 16'sd900, 3, {FH, FL, RL}, 1'b1);
        run_home(8'h19, 16'sd1250, 4, {FH, RH, FL, RL}, 1'b1);
        run_home(8'h19, 16'sd1050, 2, {FL, RL}, 1'b1);
    endtask

    task automatic t_m26();
        run_home(8'h1a, 16'sd900, 4, {FH, FL, RL, FL}, 1'b0);
        run_home(8'h1a, 16'sd1250, 3, {FH, RH, FL}, 1'b0);
        run_home(8'h1a, 16'sd1050, 1, {FL}, 1'b0);
    endtask

    // A new start in mid-run drops the old sequence for the new one
    task automatic t_restart();
        load = 1'b1;
        load_pos = 16'sd1250;
        step(1);
        load = 1'b0;
        kick(8'h15);
        step(10);
        run_home(8'h17, 16'sd1050, 1, {RL}, 1'b0);
    endtask

    initial begin
        reset = 1'b1;
        cw = 16'h0000;
        method = 8'h00;
        load = 1'b1;
        load_pos = 16'sd900;
        step(8);
        reset = 1'b0;
        load = 1'b0;
        check("outputs after reset", {move, dir_fwd, speed_high, decel, busy, done, error}, 8'h00);
        t_trigger();
        t_bad_method();
        t_m21();
        t_m22();
        t_m23();
        t_m24();
        t_m25();
        t_m26();
        t_restart();
        tally_and_finish();
    end
endmodule
